// [hw/tdmx_top.v]
`timescale 1ns/1ps
`include "tdmx_defines.vh"
module tdmx_top (
  input  wire        clk,
  input  wire        rstn,
  input  wire        ir_clk,
  input  wire [3:0]  rate_bcd,
  input  wire        aud1_clk,
  input  wire        aud1_dat,
  input  wire        aud2_clk,
  input  wire        aud2_dat,
  input  wire        pcm_dat,
  output wire        pcm_clk,
  input  wire [29:0] rb_word,
  output wire        rb_reset,
  output wire        ser_dat,
  output wire        ser_strobe,
  output wire        frame_start
);
  // Pin bundle positions
  localparam P_IR   = 0;
  localparam P_A1C  = 1;
  localparam P_A1D  = 2;
  localparam P_A2C  = 3;
  localparam P_A2D  = 4;
  localparam P_PCM  = 5;
  localparam P_RATE = 6;
  localparam P_RB   = 10;

  wire [`TDMX_PIN_W-1:0] pin_bus;
  wire [`TDMX_PIN_W-1:0] pin_lvl;
  wire [`TDMX_PIN_W-1:0] pin_rise;

  assign pin_bus = {rb_word, rate_bcd, pcm_dat, aud2_dat, aud2_clk,
                    aud1_dat, aud1_clk, ir_clk};

  tdmx_sync3 #(
    .W (`TDMX_PIN_W)
  ) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .pin  (pin_bus),
    .lvl  (pin_lvl),
    .rise (pin_rise)
  );

  wire                   ir_tick;
  wire [3:0]             rate_pin;
  wire [`TDMX_RB_W-1:0]  rb_lvl;

  assign ir_tick  = pin_rise[P_IR];
  assign rate_pin = pin_lvl[P_RATE+3:P_RATE];
  assign rb_lvl   = pin_lvl[P_RB+`TDMX_RB_W-1:P_RB];

  // Audio capture
  wire [`TDMX_AUD_W-1:0] aud1_sr;
  wire [`TDMX_AUD_W-1:0] aud2_sr;

  tdmx_sipo #(
    .W (`TDMX_AUD_W)
  ) u_aud1 (
    .clk   (clk),
    .rstn  (rstn),
    .shift (pin_rise[P_A1C]),
    .din   (pin_lvl[P_A1D]),
    .q     (aud1_sr)
  );

  tdmx_sipo #(
    .W (`TDMX_AUD_W)
  ) u_aud2 (
    .clk   (clk),
    .rstn  (rstn),
    .shift (pin_rise[P_A2C]),
    .din   (pin_lvl[P_A2D]),
    .q     (aud2_sr)
  );

  // PCM clock generation and capture
  reg  [3:0] us_div_q;
  reg  [3:0] us_cnt_q;
  reg        pcm_clk_q;
  reg        pcm_shift_q;
  reg  [3:0] rate_q;
  wire       us_tick;
  wire       half_done;

  // At or above, so a lower rate code cannot strand the divider
  assign us_tick   = ir_tick && (us_div_q >= rate_q - `TDMX_RATE_MIN);
  assign half_done = us_tick && (us_cnt_q == `TDMX_PCM_HALF_CNT);

  // Toggle every 10 us gives a free-running 50 kHz clock
  reg  [3:0] us_div_d;
  reg  [3:0] us_cnt_d;
  reg        pcm_clk_d;
  always @* begin
    us_div_d  = us_div_q;
    us_cnt_d  = us_cnt_q;
    pcm_clk_d = pcm_clk_q;
    if (ir_tick) begin
      us_div_d = us_div_q + 4'h1;
    end
    if (us_tick) begin
      us_div_d = 4'h0;
      us_cnt_d = us_cnt_q + 4'h1;
    end
    if (half_done) begin
      us_cnt_d  = 4'h0;
      pcm_clk_d = ~pcm_clk_q;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      us_div_q    <= 4'h0;
      us_cnt_q    <= 4'h0;
      pcm_clk_q   <= 1'b0;
      pcm_shift_q <= 1'b0;
    end else begin
      us_div_q    <= us_div_d;
      us_cnt_q    <= us_cnt_d;
      pcm_clk_q   <= pcm_clk_d;
      // Shift strobe marks the rising half of the PCM clock
      pcm_shift_q <= half_done && !pcm_clk_q;
    end
  end

  wire [`TDMX_PCM_HALF_W-1:0] pcm_lo;
  wire [`TDMX_PCM_HALF_W-1:0] pcm_hi;

  tdmx_sipo #(
    .W (`TDMX_PCM_HALF_W)
  ) u_pcm_lo (
    .clk   (clk),
    .rstn  (rstn),
    .shift (pcm_shift_q),
    .din   (pin_lvl[P_PCM]),
    .q     (pcm_lo)
  );

  tdmx_sipo #(
    .W (`TDMX_PCM_HALF_W)
  ) u_pcm_hi (
    .clk   (clk),
    .rstn  (rstn),
    .shift (pcm_shift_q),
    .din   (pcm_lo[`TDMX_PCM_HALF_W-1]),
    .q     (pcm_hi)
  );

  // Frame bit counter
  reg  [3:0] dec0_q;
  reg  [3:0] dec1_q;
  reg        half_q;
  reg  [3:0] dec2_q;
  reg  [2:0] sel_q;
  reg  [1:0] tv_save_q;
  reg  [9:0] out_sr_q;
  reg        ser_q;
  reg        ser_stb_q;
  reg        frame_q;
  reg        rb_reset_q;
  reg  [3:0] aud1_hold_q;
  reg  [3:0] aud2_hold_q;
  reg  [9:0] pcm_hold_q;

  function [3:0] dec_inc;
    input [3:0] v;
    begin
      if (v == `TDMX_DEC_MAX) begin
        dec_inc = 4'h0;
      end else begin
        dec_inc = v + 4'h1;
      end
    end
  endfunction

  function [2:0] sel_step;
    input [2:0] s;
    input [1:0] saved;
    begin
      case (s)
        `TDMX_SEL_PCM: sel_step = `TDMX_SEL_TV0 + {1'b0, saved};
        `TDMX_SEL_TV2: sel_step = `TDMX_SEL_TV0;
        default:       sel_step = s + 3'h1;
      endcase
    end
  endfunction

  function [1:0] tv_code;
    input [2:0] s;
    begin
      if (s >= `TDMX_SEL_TV0) begin
        tv_code = s[1:0] - 2'h1;
      end else begin
        tv_code = `TDMX_TV_CODE0;
      end
    end
  endfunction

  // Rate code, held for the whole frame; out-of-range codes run as 1 MHz
  wire [3:0] rate_ok;
  assign rate_ok = (rate_pin < `TDMX_RATE_MIN || rate_pin > `TDMX_RATE_MAX) ?
                   `TDMX_RATE_MIN : rate_pin;

  wire grp_end;
  wire dec1_end;
  wire frame_end;
  wire frame_pos0;

  assign grp_end    = (dec0_q == `TDMX_GRP_LAST);
  assign dec1_end   = grp_end && (dec1_q == `TDMX_DEC_MAX);
  assign frame_end  = dec1_end && half_q &&
                      (dec2_q + 4'h1 == rate_q);
  assign frame_pos0 = (dec0_q == 4'h0) && (dec1_q == 4'h0) &&
                      !half_q && (dec2_q == 4'h0);

  wire [2:0] sel_next;
  wire [1:0] tv_next;
  assign sel_next = frame_end ? `TDMX_SEL_SYNC0 : sel_step(sel_q, tv_save_q);
  assign tv_next  = tv_code(sel_step(sel_q, tv_save_q));

  // Hard-wired sync pattern, cut into its three groups
  wire [29:0] sync_word;
  assign sync_word = `TDMX_SYNC_WORD;

  // Group contents for the selector value about to be loaded
  reg [9:0] grp_data;
  always @* begin
    case (sel_next)
      `TDMX_SEL_SYNC0: grp_data = sync_word[29:20];
      `TDMX_SEL_SYNC1: grp_data = sync_word[19:10];
      `TDMX_SEL_SYNC2: grp_data = sync_word[9:0];
      `TDMX_SEL_AUDIO: grp_data = {aud1_hold_q, aud2_hold_q,
                                   `TDMX_FILL_BITS};
      `TDMX_SEL_PCM:   grp_data = pcm_hold_q;
      `TDMX_SEL_TV0:   grp_data = rb_lvl[29:20];
      `TDMX_SEL_TV1:   grp_data = rb_lvl[19:10];
      `TDMX_SEL_TV2:   grp_data = rb_lvl[9:0];
      default:         grp_data = 10'h000;
    endcase
  end

  // Next values of the frame bit counter and the group shifter
  reg [3:0] dec0_d;
  reg [3:0] dec1_d;
  reg       half_d;
  reg [3:0] dec2_d;
  reg [9:0] out_sr_d;
  reg [2:0] sel_d;

  always @* begin
    dec0_d   = dec_inc(dec0_q);
    dec1_d   = dec1_q;
    half_d   = half_q;
    dec2_d   = dec2_q;
    out_sr_d = {out_sr_q[8:0], 1'b0};
    sel_d    = sel_q;
    if (grp_end) begin
      dec1_d   = dec_inc(dec1_q);
      out_sr_d = grp_data;
      sel_d    = sel_next;
    end
    if (dec1_end) begin
      half_d = ~half_q;
      if (half_q) begin
        dec2_d = dec_inc(dec2_q);
      end
    end
    // Frame end restarts the count from zero
    if (frame_end) begin
      dec0_d = 4'h0;
      dec1_d = 4'h0;
      half_d = 1'b0;
      dec2_d = 4'h0;
    end
  end

  // Counters, selector and output register; counters clear on reset, output register preloads TDMX_SYNC_FIRST
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dec0_q      <= 4'h0;
      dec1_q      <= 4'h0;
      half_q      <= 1'b0;
      dec2_q      <= 4'h0;
      sel_q       <= `TDMX_SEL_SYNC0;
      tv_save_q   <= `TDMX_TV_CODE0;
      rate_q      <= `TDMX_RATE_MIN;
      out_sr_q    <= `TDMX_SYNC_FIRST;
      ser_q       <= 1'b0;
      aud1_hold_q <= 4'h0;
      aud2_hold_q <= 4'h0;
      pcm_hold_q  <= 10'h000;
    end else if (ir_tick) begin
      ser_q    <= out_sr_q[9];
      out_sr_q <= out_sr_d;
      sel_q    <= sel_d;
      dec0_q   <= dec0_d;
      dec1_q   <= dec1_d;
      half_q   <= half_d;
      dec2_q   <= dec2_d;
      // Audio and PCM words captured here go out in the next frame
      if (frame_end) begin
        tv_save_q   <= tv_next;
        rate_q      <= rate_ok;
        aud1_hold_q <= aud1_sr;
        aud2_hold_q <= aud2_sr;
        pcm_hold_q  <= {pcm_hi, pcm_lo};
      end
    end
  end

  // Word is used up once its low group sits in the output register;
  // the buffer then has ten bit times to present the next word
  wire word_taken;
  wire ser_stb_d;
  wire frame_d;
  wire rb_reset_d;
  assign word_taken = grp_end && (sel_next == `TDMX_SEL_TV2);
  assign ser_stb_d  = ir_tick;
  assign frame_d    = ir_tick && frame_pos0;
  assign rb_reset_d = ir_tick && word_taken;

  // Strobes toward the encoder and the rate buffer
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ser_stb_q  <= 1'b0;
      frame_q    <= 1'b0;
      rb_reset_q <= 1'b0;
    end else begin
      ser_stb_q  <= ser_stb_d;
      frame_q    <= frame_d;
      rb_reset_q <= rb_reset_d;
    end
  end

  assign pcm_clk     = pcm_clk_q;
  assign rb_reset    = rb_reset_q;
  assign ser_dat     = ser_q;
  assign ser_strobe  = ser_stb_q;
  assign frame_start = frame_q;
endmodule

// [inc/tdmx_defines.vh]
`ifndef TDMX_DEFINES_VH
`define TDMX_DEFINES_VH

`define TDMX_SYNC_WORD   30'h1DD3256A
`define TDMX_SYNC_FIRST  10'h1DD
`define TDMX_FILL_BITS   2'h0
`define TDMX_GRP_W       10
`define TDMX_GRP_LAST    4'h9
`define TDMX_DEC_MAX     4'h9
`define TDMX_RATE_MIN    4'h1
`define TDMX_RATE_MAX    4'h9
`define TDMX_AUD_W       4
`define TDMX_PCM_HALF_W  5
`define TDMX_RB_W        30
`define TDMX_PIN_W       40
`define TDMX_SEL_SYNC0   3'h0
`define TDMX_SEL_SYNC1   3'h1
`define TDMX_SEL_SYNC2   3'h2
`define TDMX_SEL_AUDIO   3'h3
`define TDMX_SEL_PCM     3'h4
`define TDMX_SEL_TV0     3'h5
`define TDMX_SEL_TV1     3'h6
`define TDMX_SEL_TV2     3'h7
`define TDMX_TV_CODE0    2'h0
`define TDMX_PCM_HALF_US 10
`define TDMX_PCM_HALF_CNT 4'h9

`endif

// [hw/tdmx_sync3.v]
`timescale 1ns/1ps
module tdmx_sync3 #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rstn,
  input  wire [W-1:0] pin,
  output wire [W-1:0] lvl,
  output wire [W-1:0] rise
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  reg [W-1:0] lvl_q;
  reg [W-1:0] rise_q;
  wire [W-1:0] lvl_d;

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      // Level follows only once second and third stage agree
      assign lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
    end
  endgenerate

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_q   <= {W{1'b0}};
      s2_q   <= {W{1'b0}};
      s3_q   <= {W{1'b0}};
      lvl_q  <= {W{1'b0}};
      rise_q <= {W{1'b0}};
    end else begin
      s1_q   <= pin;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      lvl_q  <= lvl_d;
      rise_q <= lvl_d & ~lvl_q;
    end
  end

  assign lvl  = lvl_q;
  assign rise = rise_q;
endmodule

// [hw/tdmx_sipo.v]
`timescale 1ns/1ps
module tdmx_sipo #(
  parameter W = 4
) (
  input  wire         clk,
  input  wire         rstn,
  input  wire         shift,
  input  wire         din,
  output wire [W-1:0] q
);
  reg [W-1:0] sr_q;

  // Oldest bit ends up in the MSB
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sr_q <= {W{1'b0}};
    end else if (shift) begin
      sr_q <= {sr_q[W-2:0], din};
    end
  end

  assign q = sr_q;
endmodule

// [tb/tdmx_top_asserts.sv]
`timescale 1ns/1ps
module tdmx_chk (
  input wire clk,
  input wire rstn,
  input wire pcm_clk,
  input wire rb_reset,
  input wire ser_dat,
  input wire ser_strobe,
  input wire frame_start
);
  reg [10:0] cnt_q;
  reg        seen_q;

  // Bits sent since the last frame start
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q  <= 11'h000;
      seen_q <= 1'b0;
    end else if (frame_start) begin
      cnt_q  <= 11'h001;
      seen_q <= 1'b1;
    end else if (ser_strobe) begin
      cnt_q <= cnt_q + 11'h001;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence quiet3;
    !ser_strobe[*3];
  endsequence
  sequence pcm_flat;
    $stable(pcm_clk)[*8];
  endsequence

  strobe_gap_a: assert property (ser_strobe |=> quiet3)
    else $error("strobe gap");
  fstart_strobe_a: assert property (frame_start |-> ser_strobe)
    else $error("start without strobe");
  fstart_bit_a: assert property (frame_start |-> !ser_dat)
    else $error("bad first bit");
  dat_hold_a: assert property ($changed(ser_dat) |-> ser_strobe)
    else $error("data moved");
  rb_pulse_a: assert property (rb_reset |=> !rb_reset)
    else $error("long rb pulse");
  rb_late_a: assert property (rb_reset |-> cnt_q > 11'h030)
    else $error("early rb pulse");
  frame_len_a: assert property (frame_start && seen_q |->
    cnt_q % 11'h0C8 == 11'h000 && cnt_q <= 11'h708 && cnt_q != 11'h000)
    else $error("bad frame length");
  pcm_hold_a: assert property ($changed(pcm_clk) |=> pcm_flat)
    else $error("pcm clock short");
endmodule

bind tdmx_top tdmx_chk u_chk (.clk(clk), .rstn(rstn), .pcm_clk(pcm_clk), .rb_reset(rb_reset),
  .ser_dat(ser_dat), .ser_strobe(ser_strobe), .frame_start(frame_start));

// [tb/tdmx_src.sv]
`timescale 1ns/1ps
module tdmx_src (
  input  wire        clk,
  input  wire        run,
  input  wire        pcm_clk,
  input  wire        rb_reset,
  output reg         ir_clk,
  output reg         aud_clk,
  output wire        aud1_dat,
  output wire        aud2_dat,
  output reg         pcm_dat,
  output wire [29:0] rb_word
);
  reg [3:0] ic_q = 4'h0;
  reg [7:0] ac_q = 8'h00;
  reg [9:0] base_q = 10'h000;
  reg       pclk_q = 1'b0;

  initial begin
    ir_clk = 1'b0;
    aud_clk = 1'b0;
    pcm_dat = 1'b0;
  end

  assign aud1_dat = 1'b1;
  assign aud2_dat = 1'b0;
  assign rb_word  = {base_q, base_q + 10'h001, base_q + 10'h002};

  // Clocks scaled so four audio bits fall in a rate-1 frame
  always @(negedge clk) begin
    ic_q <= (ic_q == 4'h4) ? 4'h0 : ic_q + 4'h1;
    if (run && ic_q == 4'h4) ir_clk <= ~ir_clk;
    ac_q <= (ac_q == 8'hF9) ? 8'h00 : ac_q + 8'h01;
    if (ac_q == 8'hF9) aud_clk <= ~aud_clk;
    pclk_q <= pcm_clk;
    if (pclk_q && !pcm_clk) pcm_dat <= ~pcm_dat;
    if (rb_reset) base_q <= base_q + 10'h003;
  end
endmodule

// [tb/tdm_frame_multiplexer_test.sv]
`timescale 1ns/1ps
module tdm_frame_multiplexer_test;
  reg        clk = 1'b0;
  reg        rstn = 1'b0;
  reg        run = 1'b0;
  reg  [3:0] rate_bcd = 4'h1;
  wire       ir_clk, aud_clk, aud1_dat, aud2_dat, pcm_dat, pcm_clk;
  wire       rb_reset, ser_dat, ser_strobe, frame_start;
  wire [29:0] rb_word;
  integer    err_total = 0;
  integer    tests_run = 0;
  integer    cyc = 0;
  integer    idx = 0;
  integer    flen = 0;
  reg        sbits [0:1799];
  reg        prev  [0:1799];

  always #20 clk = ~clk;

  tdmx_top dut (.clk(clk), .rstn(rstn), .ir_clk(ir_clk), .rate_bcd(rate_bcd),
    .aud1_clk(aud_clk), .aud1_dat(aud1_dat), .aud2_clk(aud_clk), .aud2_dat(aud2_dat),
    .pcm_dat(pcm_dat), .pcm_clk(pcm_clk), .rb_word(rb_word), .rb_reset(rb_reset),
    .ser_dat(ser_dat), .ser_strobe(ser_strobe), .frame_start(frame_start));

  tdmx_src src (.clk(clk), .run(run), .pcm_clk(pcm_clk), .rb_reset(rb_reset),
    .ir_clk(ir_clk), .aud_clk(aud_clk), .aud1_dat(aud1_dat), .aud2_dat(aud2_dat),
    .pcm_dat(pcm_dat), .rb_word(rb_word));

  task conclude;
    begin
      $display("tests_run=%0d err_total=%0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 95000) begin
      err_total = err_total + 1;
      conclude;
    end
  end

  // Serial capture off the launch edge; previous frame kept whole
  always @(negedge clk) begin
    if (ser_strobe === 1'b1) begin
      if (frame_start === 1'b1) begin
        prev = sbits;
        flen = idx;
        idx = 0;
      end
      if (idx < 1800) sbits[idx] = ser_dat;
      idx = idx + 1;
    end
  end

  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        err_total = err_total + 1;
      end
    end
  endtask

  function [9:0] grp(input integer s);
    integer i;
    begin
      grp = 10'h000;
      for (i = 0; i < 10; i = i + 1) grp = {grp[8:0], prev[s + i]};
    end
  endfunction

  task next_frame;
    begin
      @(negedge clk);
      while (frame_start !== 1'b1) @(negedge clk);
      @(negedge clk);
    end
  endtask

  task t_sync;
    reg [9:0] g;
    begin
      repeat (3) next_frame;
      g = grp(40);
      chk({grp(0), grp(10), grp(20)}, 30'h1DD3256A);
      chk(grp(30), 10'h3C0);
      chk(g[8:0] ^ g[9:1], 9'h1FF);
      chk(flen, 32'h000000C8);
    end
  endtask

  task t_tv(input [3:0] r);
    integer j;
    reg [9:0] last;
    begin
      rate_bcd = r;
      next_frame;
      next_frame;
      chk(flen, r * 32'h000000C8);
      for (j = 60; j < flen; j = j + 10)
        chk(grp(j), grp(j - 10) + 10'h001);
      last = grp(flen - 10);
      next_frame;
      chk(grp(50), last + 10'h001);
    end
  endtask

  initial begin
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    run = 1'b1;
    t_sync;
    t_tv(4'h2);
    t_tv(4'h9);
    conclude;
  end
endmodule
